// ==== design/ipc_cfg.svh ====
// Purpose: offsets, field positions and reset values of the interrupt block
// Assumes: register index times four is the byte address on the bus
// Notes: definitions only
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define IPC_IDX_PRIO_FOUR 12'hf90
`define IPC_IDX_PRIO_FIVE 12'hf99
`define IPC_IDX_PRIO_THREE 12'hfa5
`define IPC_IDX_CAUSE 12'hfd0
`define IPC_IDX_TMR_CFG 12'hfd5
`define IPC_IDX_CTRL_THREE 12'hff0
`define IPC_IDX_CTRL_TWO 12'hff1
`define IPC_IDX_CTRL_ONE 12'hff2
// ----------------------------------------
// reset values
// ----------------------------------------
`define IPC_PRIO_RST 8'hff
`define IPC_PRIO5_RST 6'h3f
`define IPC_CAUSE_RST 6'h3c
`define IPC_CTRL1_RST 8'h00
`define IPC_CTRL2_RST 7'h7f
`define IPC_CTRL3_RST 8'hc0
`define IPC_TMR_CFG_RST 1'h0
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define IPC_CAUSE_PRIO_EN 7
`define IPC_CAUSE_RO_MASK 6'h0c
`define IPC_C1_GLOBAL 7
`define IPC_C1_SECOND 6
`define IPC_C1_TMR_EN 5
`define IPC_C1_PIN0_EN 4
`define IPC_C1_PORT_EN 3
`define IPC_C1_TMR_FLAG 2
`define IPC_C1_PIN0_FLAG 1
`define IPC_C1_PORT_FLAG 0
`define IPC_C2_TMR_PRIO 2
`define IPC_C2_PIN3_PRIO 1
`define IPC_C2_PORT_PRIO 0
`define IPC_C3_PIN2_PRIO 7
`define IPC_C3_PIN1_PRIO 6
`define IPC_TMR_MODE16 0
`define IPC_RESP_OKAY 2'h0
`define IPC_RESP_SLVERR 2'h2
`endif

// ==== design/ipc_pkg.sv ====
// Purpose: shared types of the interrupt block
// Assumes: constants live in ipc_cfg.svh
// Notes: service level states of the core
package ipc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_NEST} ipc_state_t;
endpackage

// ==== design/ipc_reg_if.sv ====
// Purpose: register access path between bus slave and register file
// Assumes: one clock
// Notes: write strobe is one cycle, read data is combinational
`timescale 1ns/1ps
interface ipc_reg_if;
	logic wrEn;
	logic [11:0] wrIdx;
	logic [7:0] wrData;
	logic wrHit;
	logic [11:0] rdIdx;
	logic [7:0] rdData;
	logic rdHit;
	modport slave (output wrEn, wrIdx, wrData, rdIdx, input wrHit, rdData, rdHit);
	modport regs (input wrEn, wrIdx, wrData, rdIdx, output wrHit, rdData, rdHit);
endinterface

// ==== design/ipc_edge_det.sv ====
// Purpose: per-bit edge or change detector
// Assumes: inputs synchronous to clk
// Notes: first cycle after reset only primes the history
`timescale 1ns/1ps
module ipc_edge_det #(
	parameter int N = 4
) (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, low
	input wire logic [N-1:0] level, // sampled pins
	input wire logic [N-1:0] riseSel, // 1 rising, 0 falling
	input wire logic anyEdge, // report every change
	output logic [N-1:0] hit // one-cycle detect
);
	logic [N-1:0] prev;
	logic armed;
	// history of the pins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prev <= '0;
			armed <= 1'b0;
		end else begin
			prev <= level;
			armed <= 1'b1;
		end
	end
	// edge decode per bit
	for (genvar i = 0; i < N; i++) begin : g_bit
		assign hit[i] = armed & (anyEdge ? (level[i] ^ prev[i]) :
			(riseSel[i] ? (level[i] & ~prev[i]) : (~level[i] & prev[i])));
	end
endmodule // ipc_edge_det

// ==== design/ipc_axil.sv ====
// Purpose: AXI4-Lite slave for the byte-wide register file
// Assumes: one write and one read in flight at most
// Notes: write answers one cycle after both halves held; read one cycle after address
`timescale 1ns/1ps
`include "ipc_cfg.svh"
module ipc_axil #(
	parameter int ADDR_W = 14
) (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, low
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [ADDR_W-1:0] awaddr, // write byte address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [ADDR_W-1:0] araddr, // read byte address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	ipc_reg_if.slave rif // register side
);
	logic awHave, wHave, wStb0, rdPend, doWr;
	assign doWr = awHave & wHave & ~bvalid;
	assign rif.wrEn = doWr & wStb0;
	// write address capture
	always_ff @(posedge clk) begin
		if (!nrst) begin
			awHave <= 1'b0;
			awready <= 1'b0;
			rif.wrIdx <= '0;
		end else if (awvalid && awready) begin
			awHave <= 1'b1;
			awready <= 1'b0;
			rif.wrIdx <= awaddr[ADDR_W-1:2];
		end else begin
			if (doWr) awHave <= 1'b0;
			if (doWr || !awHave) awready <= 1'b1;
		end
	end
	// write data capture
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wHave <= 1'b0;
			wready <= 1'b0;
			rif.wrData <= '0;
			wStb0 <= 1'b0;
		end else if (wvalid && wready) begin
			wHave <= 1'b1;
			wready <= 1'b0;
			rif.wrData <= wdata[7:0];
			wStb0 <= wstrb[0];
		end else begin
			if (doWr) wHave <= 1'b0;
			if (doWr || !wHave) wready <= 1'b1;
		end
	end
	// write response
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= `IPC_RESP_OKAY;
		end else if (doWr) begin
			bvalid <= 1'b1;
			bresp <= rif.wrHit ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// read channel
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arready <= 1'b0;
			rdPend <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `IPC_RESP_OKAY;
			rif.rdIdx <= '0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rdPend <= 1'b1;
			rif.rdIdx <= araddr[ADDR_W-1:2];
		end else if (rdPend) begin
			rdPend <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h0, rif.rdData};
			rresp <= rif.rdHit ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
		end else if (rvalid) begin
			if (rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end else begin
			arready <= 1'b1;
		end
	end
endmodule // ipc_axil

// ==== design/ipc_top.sv ====
// Purpose: interrupt priorities, pin/timer/port sources, reset cause, entry context
// Assumes: all inputs synchronous to clk; peripheral requests are flag and enable
// Notes: registers are byte wide, one per aligned bus word
// Functional notes
// - group three priorities, eight bits, reset high
// - group four: capture units, enhanced three
// - cause register bit7 priority enable, bit6 zero
// - six reset cause flags, two read-only
// - pin edge select: rising or falling
// - edge sets pin flag; request needs enable
// - enabled pins wake from sleep or idle
// - deep sleep: pin zero restarts at reset
// - pins one-three have priority; zero high
// - timer zero flag on 8/16-bit wrap
// - timer zero enable and priority bits
// - port upper nibble change sets flag
// - entry pushes pc, saves fast context
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ipc_cfg.svh"
module ipc_top
	import ipc_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int PERIPH_N = 22
) (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, low
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [ADDR_W-1:0] awaddr, // write byte address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [ADDR_W-1:0] araddr, // read byte address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	input wire logic [PERIPH_N-1:0] periphReq, // peripheral flag and enable
	input wire logic [3:0] intPin, // external pins, 0..3
	input wire logic [3:0] portPins, // port upper nibble
	input wire logic tmrTick, // timer zero count pulse
	input wire logic [5:0] causeEvt, // hardware sets cause flags
	input wire logic [5:0] causeClr, // hardware clears cause flags
	input wire logic sleepMode, // sleep or idle active
	input wire logic deepSleep, // deep sleep active
	input wire logic entryTake, // core vectors now
	input wire logic retTake, // core returns from service
	input wire logic [20:0] pcIn, // return address
	input wire logic [7:0] wregIn, // working register
	input wire logic [7:0] statusIn, // status register
	input wire logic [7:0] bsrIn, // bank select register
	output logic irqHigh, // high vector request
	output logic irqLow, // low vector request
	output logic wakeReq, // wake from sleep or idle
	output logic wakePor, // deep sleep wake, reset vector
	output logic pushEn, // push return address
	output logic [20:0] pushPc, // address to push
	output logic [7:0] fastW, // fast stack working reg
	output logic [7:0] fastStatus, // fast stack status
	output logic [7:0] fastBsr // fast stack bank select
);
	// ----------------------------------------
	// registers and internal state
	// ----------------------------------------
	ipc_reg_if rif ();
	logic [7:0] prioThree, prioFour, ctrlOne, ctrlThree;
	logic [5:0] prioFive, causeFlags;
	logic [6:0] ctrlTwo;
	logic prioEnable, tmrMode16;
	logic [15:0] tmrCount;
	logic [3:0] pinHit, portHit, edgeSel, pinEn, pinFlags, wakeEn;
	logic [5:0] coreReq, corePrio;
	logic [PERIPH_N-1:0] perPrio;
	logic tmrWrap, highAct, lowAct;
	ipc_state_t state;

	// ----------------------------------------
	// bus slave and detectors
	// ----------------------------------------
	ipc_axil #(.ADDR_W(ADDR_W)) u_axil (
		.clk(clk), .nrst(nrst),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.rif(rif)
	);
	assign edgeSel = {ctrlTwo[3], ctrlTwo[4], ctrlTwo[5], ctrlTwo[6]};
	ipc_edge_det #(.N(4)) u_pins (
		.clk(clk), .nrst(nrst), .level(intPin), .riseSel(edgeSel),
		.anyEdge(1'b0), .hit(pinHit)
	);
	ipc_edge_det #(.N(4)) u_port (
		.clk(clk), .nrst(nrst), .level(portPins), .riseSel(4'h0),
		.anyEdge(1'b1), .hit(portHit)
	);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// peripheral priority groups
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prioThree <= `IPC_PRIO_RST;
			prioFour <= `IPC_PRIO_RST;
			prioFive <= `IPC_PRIO5_RST;
		end else if (rif.wrEn) begin
			if (rif.wrIdx == `IPC_IDX_PRIO_THREE) prioThree <= rif.wrData;
			if (rif.wrIdx == `IPC_IDX_PRIO_FOUR) prioFour <= rif.wrData;
			if (rif.wrIdx == `IPC_IDX_PRIO_FIVE) prioFive <= rif.wrData[5:0];
		end
	end
	// priority enable and cause flags, hardware set wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prioEnable <= 1'b0;
			causeFlags <= `IPC_CAUSE_RST;
		end else if (rif.wrEn && rif.wrIdx == `IPC_IDX_CAUSE) begin
			prioEnable <= rif.wrData[`IPC_CAUSE_PRIO_EN];
			causeFlags <= ((rif.wrData[5:0] & ~`IPC_CAUSE_RO_MASK) |
				(causeFlags & `IPC_CAUSE_RO_MASK & ~causeClr)) | causeEvt;
		end else begin
			causeFlags <= (causeFlags & ~causeClr) | causeEvt;
		end
	end
	// control one: enables and hardware flags
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrlOne <= `IPC_CTRL1_RST;
		end else begin
			if (rif.wrEn && rif.wrIdx == `IPC_IDX_CTRL_ONE) ctrlOne <= rif.wrData;
			if (tmrWrap) ctrlOne[`IPC_C1_TMR_FLAG] <= 1'b1;
			if (pinHit[0]) ctrlOne[`IPC_C1_PIN0_FLAG] <= 1'b1;
			if (|portHit) ctrlOne[`IPC_C1_PORT_FLAG] <= 1'b1;
		end
	end
	// control two: edge selects and priorities
	always_ff @(posedge clk) begin
		if (!nrst) ctrlTwo <= `IPC_CTRL2_RST;
		else if (rif.wrEn && rif.wrIdx == `IPC_IDX_CTRL_TWO) ctrlTwo <= rif.wrData[6:0];
	end
	// control three: pin one-three flags and enables, pin one-two priorities
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrlThree <= `IPC_CTRL3_RST;
		end else begin
			if (rif.wrEn && rif.wrIdx == `IPC_IDX_CTRL_THREE) ctrlThree <= rif.wrData;
			for (int i = 1; i < 4; i++) begin
				if (pinHit[i]) ctrlThree[i-1] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// timer zero
	// ----------------------------------------
	assign tmrWrap = tmrTick & (tmrMode16 ? (tmrCount == 16'hffff) :
		(tmrCount[7:0] == 8'hff));
	// mode bit and count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tmrMode16 <= `IPC_TMR_CFG_RST;
			tmrCount <= 16'h0000;
		end else begin
			if (rif.wrEn && rif.wrIdx == `IPC_IDX_TMR_CFG)
				tmrMode16 <= rif.wrData[`IPC_TMR_MODE16];
			if (tmrTick && tmrMode16) tmrCount <= tmrCount + 16'h0001;
			else if (tmrTick) tmrCount[7:0] <= tmrCount[7:0] + 8'h01;
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_comb begin
		rif.rdData = 8'h00;
		rif.rdHit = 1'b1;
		unique case (rif.rdIdx)
			`IPC_IDX_PRIO_THREE: rif.rdData = prioThree;
			`IPC_IDX_PRIO_FOUR: rif.rdData = prioFour;
			`IPC_IDX_PRIO_FIVE: rif.rdData = {2'h0, prioFive};
			`IPC_IDX_CAUSE: rif.rdData = {prioEnable, 1'b0, causeFlags};
			`IPC_IDX_TMR_CFG: rif.rdData = {7'h00, tmrMode16};
			`IPC_IDX_CTRL_ONE: rif.rdData = ctrlOne;
			`IPC_IDX_CTRL_TWO: rif.rdData = {1'b0, ctrlTwo};
			`IPC_IDX_CTRL_THREE: rif.rdData = ctrlThree;
			default: rif.rdHit = 1'b0;
		endcase
	end
	// write decode for the response
	always_comb begin
		unique case (rif.wrIdx)
			`IPC_IDX_PRIO_THREE, `IPC_IDX_PRIO_FOUR, `IPC_IDX_PRIO_FIVE,
			`IPC_IDX_CAUSE, `IPC_IDX_TMR_CFG, `IPC_IDX_CTRL_ONE,
			`IPC_IDX_CTRL_TWO, `IPC_IDX_CTRL_THREE: rif.wrHit = 1'b1;
			default: rif.wrHit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// source arbitration
	// ----------------------------------------
	assign pinFlags = {ctrlThree[2:0], ctrlOne[`IPC_C1_PIN0_FLAG]};
	assign pinEn = {ctrlThree[5:3], ctrlOne[`IPC_C1_PIN0_EN]};
	// requests gated by their enables
	assign coreReq = {ctrlOne[`IPC_C1_PORT_FLAG] & ctrlOne[`IPC_C1_PORT_EN],
		ctrlOne[`IPC_C1_TMR_FLAG] & ctrlOne[`IPC_C1_TMR_EN],
		pinFlags & pinEn};
	// pin zero fixed high, others from control bits
	assign corePrio = {ctrlTwo[`IPC_C2_PORT_PRIO], ctrlTwo[`IPC_C2_TMR_PRIO],
		ctrlTwo[`IPC_C2_PIN3_PRIO], ctrlThree[`IPC_C3_PIN2_PRIO],
		ctrlThree[`IPC_C3_PIN1_PRIO], 1'b1};
	assign perPrio = {prioFive, prioFour, prioThree};
	// two levels with priorities, one level without
	always_comb begin
		if (prioEnable) begin
			highAct = ctrlOne[`IPC_C1_GLOBAL] &
				(|(coreReq & corePrio) | |(periphReq & perPrio));
			lowAct = ctrlOne[`IPC_C1_GLOBAL] & ctrlOne[`IPC_C1_SECOND] &
				(|(coreReq & ~corePrio) | |(periphReq & ~perPrio));
		end else begin
			highAct = ctrlOne[`IPC_C1_GLOBAL] &
				(|coreReq | (ctrlOne[`IPC_C1_SECOND] & |periphReq));
			lowAct = 1'b0;
		end
	end
	// vector requests
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irqHigh <= 1'b0;
			irqLow <= 1'b0;
		end else begin
			irqHigh <= highAct & (state == ST_IDLE || state == ST_LOW);
			irqLow <= lowAct & ~highAct & (state == ST_IDLE);
		end
	end
	// service level tracking
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else if (entryTake && irqHigh) begin
			state <= (state == ST_LOW) ? ST_NEST : ST_HIGH;
		end else if (entryTake && irqLow) begin
			state <= ST_LOW;
		end else if (retTake) begin
			unique case (state)
				ST_NEST: state <= ST_LOW;
				ST_LOW, ST_HIGH: state <= ST_IDLE;
				ST_IDLE: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// context save on entry
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pushEn <= 1'b0;
			pushPc <= '0;
			fastW <= 8'h00;
			fastStatus <= 8'h00;
			fastBsr <= 8'h00;
		end else begin
			pushEn <= entryTake & (irqHigh | irqLow);
			if (entryTake && (irqHigh || irqLow)) begin
				pushPc <= pcIn;
				fastW <= wregIn;
				fastStatus <= statusIn;
				fastBsr <= bsrIn;
			end
		end
	end

	// ----------------------------------------
	// wake from power-managed modes
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wakeEn <= 4'h0;
			wakeReq <= 1'b0;
			wakePor <= 1'b0;
		end else begin
			if (!sleepMode) wakeEn <= pinEn;
			wakeReq <= sleepMode & ~deepSleep & |(pinFlags & wakeEn);
			wakePor <= deepSleep & pinHit[0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		entryTake && (irqHigh || irqLow);
	endsequence
	sequence s_nest_in;
		state == ST_LOW ##0 entryTake && irqHigh;
	endsequence
	property p_prio3_rst;
		!$past(nrst) |-> prioThree == 8'hff;
	endproperty
	a_prio3_rst: assert property (p_prio3_rst) else $error("group three reset");
	property p_prio4_rst;
		!$past(nrst) |-> prioFour == 8'hff && prioFive == 6'h3f;
	endproperty
	a_prio4_rst: assert property (p_prio4_rst) else $error("group four reset");
	property p_prio5_read;
		rif.rdIdx == `IPC_IDX_PRIO_FIVE |-> rif.rdData[7:6] == 2'h0;
	endproperty
	a_prio5_read: assert property (p_prio5_read) else $error("group five top");
	property p_cause_read;
		rif.rdIdx == `IPC_IDX_CAUSE |-> !rif.rdData[6] && rif.rdData[7] == prioEnable;
	endproperty
	a_cause_read: assert property (p_cause_read) else $error("cause read");
	property p_cause_ro;
		rif.wrEn && rif.wrIdx == `IPC_IDX_CAUSE && causeEvt == 6'h0 && causeClr == 6'h0
			|=> causeFlags[3:2] == $past(causeFlags[3:2]);
	endproperty
	a_cause_ro: assert property (p_cause_ro) else $error("read-only cause");
	property p_pin_edge;
		$past(nrst) && ctrlTwo[6] && $rose(intPin[0]) |=> ctrlOne[`IPC_C1_PIN0_FLAG];
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("pin edge lost");
	property p_pin0_high;
		prioEnable && ctrlOne[7] && ctrlOne[4] && ctrlOne[1] && state == ST_IDLE
			|=> irqHigh;
	endproperty
	a_pin0_high: assert property (p_pin0_high) else $error("pin zero not high");
	property p_deep_wake;
		$past(nrst) && deepSleep && ctrlTwo[6] && $rose(intPin[0]) |=> wakePor;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("deep wake");
	property p_timer_wrap;
		tmrTick && !tmrMode16 && tmrCount[7:0] == 8'hff |=> ctrlOne[`IPC_C1_TMR_FLAG];
	endproperty
	a_timer_wrap: assert property (p_timer_wrap) else $error("timer wrap");
	property p_port_change;
		$past(nrst) && portPins != $past(portPins) |=> ctrlOne[`IPC_C1_PORT_FLAG];
	endproperty
	a_port_change: assert property (p_port_change) else $error("port change");
	property p_context;
		s_take |=> pushEn && pushPc == $past(pcIn) && fastW == $past(wregIn);
	endproperty
	a_context: assert property (p_context) else $error("context save");
	property p_preempt;
		s_nest_in |=> state == ST_NEST ##1 (state == ST_NEST || state == ST_LOW);
	endproperty
	a_preempt: assert property (p_preempt) else $error("preempt");
endmodule // ipc_top

// ==== bench/ipc_core_model.sv ====
// Purpose: core side model taking vectors and returning
// Assumes: irq levels registered by the block
// Notes: slow delays entry at random
`timescale 1ns/1ps
module ipc_core_model (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, low
	input wire logic irqHigh, // high request
	input wire logic irqLow, // low request
	input wire logic slow, // late answers
	output logic entryTake, // vector pulse
	output logic retTake // return pulse
);
	int cnt, held;
	logic inLow, go;
	// enter on request, return after a short service; high may preempt low
	always @(posedge clk) begin
		if (!nrst) begin
			entryTake <= 1'b0;
			retTake <= 1'b0;
			cnt <= 0;
			held <= 0;
			inLow <= 1'b0;
		end else if (inLow && irqHigh && cnt > 1 && cnt < 5) begin
			entryTake <= 1'b1; // nest over the low service
			retTake <= 1'b0;
			held <= cnt;
			cnt <= 6;
			inLow <= 1'b0;
		end else if (cnt > 0) begin
			entryTake <= 1'b0;
			retTake <= (cnt == 1);
			cnt <= (cnt == 1) ? held : cnt - 1;
			held <= (cnt == 1) ? 0 : held;
			inLow <= (cnt == 1) ? (held > 0) : inLow;
		end else begin
			go = (irqHigh || irqLow) && !(slow && ($urandom % 2 == 1));
			entryTake <= go;
			retTake <= 1'b0;
			cnt <= go ? 6 : 0;
			inLow <= go && irqLow;
		end
	end
endmodule // ipc_core_model

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench of the interrupt block
// Assumes: bus answers within 200 cycles
// Notes: expectations from register layout
`timescale 1ns/1ps
`include "ipc_cfg.svh"
module tb_top;
	localparam logic [11:0] P3 = `IPC_IDX_PRIO_THREE;
	localparam logic [11:0] P4 = `IPC_IDX_PRIO_FOUR;
	localparam logic [11:0] P5 = `IPC_IDX_PRIO_FIVE;
	localparam logic [11:0] RC = `IPC_IDX_CAUSE;
	localparam logic [11:0] C1 = `IPC_IDX_CTRL_ONE;
	logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, tmrTick = 1'b0, sleepMode = 1'b0;
	logic deepSleep = 1'b0, slow = 1'b0;
	logic [13:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [21:0] periphReq = '0;
	logic [3:0] intPin = '0, portPins = '0;
	logic [20:0] pcIn = '0, pushPc;
	logic [7:0] wregIn = '0, statusIn = '0, bsrIn = '0, fastW, fastStatus, fastBsr, v;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, entryTake, retTake;
	logic irqHigh, irqLow, wakeReq, wakePor, pushEn;
	logic [44:0] ctx;
	int mismatches = 0, checked = 0, s;
	always #4 clk = ~clk;
	ipc_top i_ipc_top (.clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .periphReq, .intPin, .portPins, .tmrTick, .causeEvt(6'h00),
		.causeClr(6'h00), .sleepMode, .deepSleep, .entryTake, .retTake, .pcIn, .wregIn,
		.statusIn, .bsrIn, .irqHigh, .irqLow, .wakeReq, .wakePor, .pushEn, .pushPc, .fastW,
		.fastStatus, .fastBsr);
	ipc_core_model i_ipc_core_model (.clk, .nrst, .irqHigh, .irqLow, .slow, .entryTake,
		.retTake);
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic hang(input int n);
		if (n >= 200) begin
			mismatches++;
			final_report();
		end
	endtask
	// bus write, one word
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		hang(n);
		chk(bresp, r);
	endtask
	// bus read and compare
	task automatic rd(input logic [11:0] idx, input logic [31:0] e, input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= {idx, 2'b00};
		do begin
			@(posedge clk);
			if (arready && arvalid) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 200);
		rready <= 1'b0;
		hang(n);
		chk(rdata, e);
		chk(rresp, r);
	endtask
	// wait for one of the request outputs
	task automatic wait_on(input int k);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(k == 0 ? irqHigh : k == 1 ? irqLow : k == 2 ? wakeReq : wakePor) && n < 200);
		hang(n);
	endtask
	// saved context at entry
	always @(posedge clk) begin
		if (pushEn) chk(pushPc, ctx[44:24]);
		if (pushEn) chk({fastW, fastStatus, fastBsr}, ctx[23:0]);
		if (entryTake && (irqHigh || irqLow)) ctx = {pcIn, wregIn, statusIn, bsrIn};
	end
	initial begin
		void'($urandom(32'hf678));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(P3, 32'hff);
		rd(P4, 32'hff);
		rd(P5, 32'h3f);
		rd(RC, 32'h3c);
		rd(12'h000, 32'h0, `IPC_RESP_SLVERR);
		wr(12'h000, 8'h00, `IPC_RESP_SLVERR);
		$display("reset values done");
		for (s = 0; s < 8; s++) begin
			v = 8'($urandom);
			wr(P3, v);
			rd(P3, {24'h0, v});
			wr(P4, ~v);
			rd(P4, {24'h0, ~v});
			wr(P5, v);
			rd(P5, {26'h0, v[5:0]});
		end
		wr(RC, 8'hff);
		rd(RC, 32'hbf);
		wr(RC, 8'h40);
		rd(RC, 32'h0c);
		$display("register access done");
		for (s = 0; s < 2; s++) begin
			intPin[0] <= (s == 0);
			pcIn <= 21'($urandom);
			{wregIn, statusIn, bsrIn} <= 24'($urandom);
			wr(`IPC_IDX_CTRL_TWO, s ? 8'h7f : 8'h3f);
			wr(C1, 8'h90);
			intPin[0] <= (s == 1);
			wait_on(0);
			repeat (8) @(posedge clk);
			wr(C1, 8'h90);
			intPin[0] <= (s == 0);
			repeat (3) @(posedge clk);
			rd(C1, 32'h90);
		end
		$display("pin edges done");
		wr(`IPC_IDX_TMR_CFG, 8'h00);
		wr(C1, 8'h20);
		repeat (255) begin
			@(posedge clk);
			tmrTick <= 1'b1;
		end
		@(posedge clk);
		tmrTick <= 1'b0;
		rd(C1, 32'h20);
		tmrTick <= 1'b1;
		@(posedge clk);
		tmrTick <= 1'b0;
		rd(C1, 32'h24);
		wr(C1, 8'h84);
		repeat (3) @(posedge clk);
		chk(irqHigh, 1'b0);
		wr(C1, 8'ha4);
		wait_on(0);
		wr(C1, 8'h08);
		portPins <= 4'h4;
		rd(C1, 32'h09);
		$display("timer and port done");
		wr(RC, 8'h80);
		wr(P3, 8'hfe);
		wr(C1, 8'hc0);
		slow <= 1'b1;
		periphReq <= 22'h1;
		wait_on(1);
		wr(P3, 8'hff);
		wait_on(0);
		periphReq <= 22'h0;
		$display("priority levels done");
		wr(C1, 8'h10);
		sleepMode <= 1'b1;
		intPin[0] <= 1'b1;
		wait_on(2);
		intPin[0] <= 1'b0;
		deepSleep <= 1'b1;
		repeat (3) @(posedge clk);
		intPin[0] <= 1'b1;
		wait_on(3);
		$display("wake done");
		final_report();
	end
endmodule // tb_top
